// [dcf_fifo.sv]
// Nine-bit FIFO with selectable depth, four active-low flags and APB control
// Notes on behaviour
// - Word is stored on a clock edge when enable A is low and enable B high.
// - Holding both write enables active stores one word every clock cycle.
// - Read port has two read enables and delivers one word per cycle.
// - Input and output data are nine bits wide.
// - Depth selects 16K, 64K or 128K words.
// - Reads and writes may happen in the same cycle.
// - Four flag outputs: empty, full, almost empty, almost full.
// - Almost-empty and almost-full thresholds are set to the exact word.
// - Thresholds reset to seven words from empty and from full.
// - Empty and almost-empty flags change only with the read-side logic.
// - Full and almost-full flags change only with the write-side logic.
// - A flag keeps a new value for at least one clock cycle.
// - Writes while full are ignored and storage is left unchanged.
// - A read happens only when both read enables are low and not empty.
// - Reset returns the buffer to empty; reset before first use.
// - Output data is driven while output enable is low, released when high; the code registers it, so rd_data_oe is the inverse of out_en_n one clock later.
//
// Added by the designer: the APB interface to the registers and the address map.
`default_nettype none
module dcf_fifo (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [dcf_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      rst_n,
	input  wire logic [dcf_pkg::DATA_W-1:0] wr_data,
	input  wire logic                      wr_en_a_n,
	input  wire logic                      wr_en_b_or_load_n,
	input  wire logic                      rd_en_a_n,
	input  wire logic                      rd_en_b_n,
	input  wire logic                      out_en_n,
	output logic      [dcf_pkg::DATA_W-1:0] rd_data,
	output logic                           rd_data_oe,
	output logic                           empty_n,
	output logic                           full_n,
	output logic                           almost_empty_n,
	output logic                           almost_full_n,
	output logic                           irq
);
	import dcf_pkg::*;

	logic [DATA_W-1:0] mem [0:(1 << ADDR_W)-1];

	logic [1:0]        depth_r;
	logic [OFS_W-1:0]  ae_ofs_r;
	logic [OFS_W-1:0]  af_ofs_r;
	logic              flush_r;
	logic [IRQ_W-1:0]  irq_stat_r;
	logic [IRQ_W-1:0]  irq_mask_r;
	logic [PTR_W-1:0]  wptr_r;
	logic [PTR_W-1:0]  rptr_r;
	logic [PTR_W-1:0]  level_r;
	logic [31:0]       prdata_r;
	logic              pready_r;
	logic              pslverr_r;
	logic [DATA_W-1:0] rd_data_r;
	logic              rd_data_oe_r;
	logic              empty_n_r;
	logic              full_n_r;
	logic              almost_empty_n_r;
	logic              almost_full_n_r;
	logic              irq_r;

	logic              clr;
	logic              setup;
	logic              wr_acc;
	logic              mapped;
	logic [31:0]       rd_word;
	logic [PTR_W-1:0]  depth_words;
	logic [ADDR_W-1:0] addr_mask;
	logic              wr_req;
	logic              rd_req;
	logic              wr_fire;
	logic              rd_fire;
	logic [PTR_W-1:0]  wptr_nxt;
	logic [PTR_W-1:0]  rptr_nxt;
	logic [PTR_W-1:0]  wptr_rd;
	logic [PTR_W-1:0]  rptr_wr;
	logic [PTR_W-1:0]  wcount_nxt;
	logic [PTR_W-1:0]  rcount_nxt;
	logic              full_nxt;
	logic              empty_nxt;
	logic [IRQ_W-1:0]  irq_evt;
	logic [IRQ_W-1:0]  irq_w1c;

	assign prdata         = prdata_r;
	assign pready         = pready_r;
	assign pslverr        = pslverr_r;
	assign rd_data        = rd_data_r;
	assign rd_data_oe     = rd_data_oe_r;
	assign empty_n        = empty_n_r;
	assign full_n         = full_n_r;
	assign almost_empty_n = almost_empty_n_r;
	assign almost_full_n  = almost_full_n_r;
	assign irq            = irq_r;

	// Register bus: no wait state; the setup cycle lets every answer come from a flop
	assign setup  = psel & ~penable;
	assign wr_acc = psel & penable & pready_r & pwrite;

	always_comb begin
		mapped  = 1'b1;
		rd_word = WORD_ZERO;
		unique case (paddr)
			REG_CTRL:     rd_word[CTRL_DEPTH_MSB:CTRL_DEPTH_LSB] = depth_r;
			REG_AE_OFS:   rd_word[OFS_W-1:0] = ae_ofs_r;
			REG_AF_OFS:   rd_word[OFS_W-1:0] = af_ofs_r;
			REG_STATUS: begin
				rd_word[ST_EMPTY_N]  = empty_n_r;
				rd_word[ST_AEMPTY_N] = almost_empty_n_r;
				rd_word[ST_FULL_N]   = full_n_r;
				rd_word[ST_AFULL_N]  = almost_full_n_r;
			end
			REG_IRQ_STAT: rd_word[IRQ_W-1:0] = irq_stat_r;
			REG_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask_r;
			REG_LEVEL:    rd_word[PTR_W-1:0] = level_r;
			default:      mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= WORD_ZERO;
		end else begin
			pready_r  <= setup;
			pslverr_r <= setup & ~mapped;
			prdata_r  <= (setup & ~pwrite) ? rd_word : WORD_ZERO;
		end
	end

	// Depth and thresholds; changing depth with data stored scrambles the order
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			depth_r  <= DEPTH_RST;
			ae_ofs_r <= OFS_RST;
			af_ofs_r <= OFS_RST;
		end else if (wr_acc) begin
			if (paddr == REG_CTRL)
				depth_r <= pwdata[CTRL_DEPTH_MSB:CTRL_DEPTH_LSB];
			if (paddr == REG_AE_OFS)
				ae_ofs_r <= pwdata[OFS_W-1:0];
			if (paddr == REG_AF_OFS)
				af_ofs_r <= pwdata[OFS_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			flush_r <= 1'b0;
		else
			flush_r <= wr_acc & (paddr == REG_CTRL) & pwdata[CTRL_FLUSH_BIT];
	end

	assign clr         = ~rst_n | flush_r;
	assign depth_words = dcf_depth_words(depth_r);
	assign addr_mask   = ADDR_W'(depth_words - PTR_ONE);

	assign wr_req  = ~wr_en_a_n & wr_en_b_or_load_n;
	assign rd_req  = ~rd_en_a_n & ~rd_en_b_n;
	assign wr_fire = wr_req & full_n_r & ~clr;
	assign rd_fire = rd_req & empty_n_r & ~clr;

	assign wptr_nxt = wr_fire ? wptr_r + PTR_ONE : wptr_r;
	assign rptr_nxt = rd_fire ? rptr_r + PTR_ONE : rptr_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr_r <= PTR_ZERO;
			rptr_r <= PTR_ZERO;
		end else if (clr) begin
			wptr_r <= PTR_ZERO;
			rptr_r <= PTR_ZERO;
		end else begin
			wptr_r <= wptr_nxt;
			rptr_r <= rptr_nxt;
		end
	end

	// Storage has no reset; the flags keep stale words from being read
	always_ff @(posedge pclk) begin
		if (wr_fire)
			mem[wptr_r[ADDR_W-1:0] & addr_mask] <= wr_data;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rd_data_r <= DATA_ZERO;
		else if (rd_fire)
			rd_data_r <= mem[rptr_r[ADDR_W-1:0] & addr_mask];
	end

	// No tristate inside the design; the pad uses this enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rd_data_oe_r <= 1'b0;
		else
			rd_data_oe_r <= ~out_en_n;
	end

	dcf_gray_sync u_wptr_to_rd (
		.clk     (pclk),
		.rst_n   (presetn),
		.clr     (clr),
		.bin_in  (wptr_r),
		.bin_out (wptr_rd)
	);

	dcf_gray_sync u_rptr_to_wr (
		.clk     (pclk),
		.rst_n   (presetn),
		.clr     (clr),
		.bin_in  (rptr_r),
		.bin_out (rptr_wr)
	);

	// Each side sees the far pointer late, so flags err toward safe
	assign wcount_nxt = wptr_nxt - rptr_wr;
	assign rcount_nxt = wptr_rd - rptr_nxt;
	assign full_nxt   = wcount_nxt >= depth_words;
	assign empty_nxt  = rcount_nxt == PTR_ZERO;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			full_n_r        <= 1'b1;
			almost_full_n_r <= 1'b1;
		end else if (clr) begin
			full_n_r        <= 1'b1;
			almost_full_n_r <= 1'b1;
		end else begin
			full_n_r        <= ~full_nxt;
			almost_full_n_r <= ~(wcount_nxt >= depth_words - PTR_W'(af_ofs_r));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			empty_n_r        <= 1'b0;
			almost_empty_n_r <= 1'b0;
			level_r          <= PTR_ZERO;
		end else if (clr) begin
			empty_n_r        <= 1'b0;
			almost_empty_n_r <= 1'b0;
			level_r          <= PTR_ZERO;
		end else begin
			empty_n_r        <= ~empty_nxt;
			almost_empty_n_r <= rcount_nxt > PTR_W'(ae_ofs_r);
			level_r          <= rcount_nxt;
		end
	end

	// Full and empty entries and refused requests are the interrupt events
	always_comb begin
		irq_evt            = IRQ_ZERO;
		irq_evt[IRQ_FULL]  = full_n_r & full_nxt & ~clr;
		irq_evt[IRQ_EMPTY] = empty_n_r & empty_nxt & ~clr;
		irq_evt[IRQ_OVF]   = wr_req & ~full_n_r & ~clr;
		irq_evt[IRQ_UDF]   = rd_req & ~empty_n_r & ~clr;
	end

	assign irq_w1c = (wr_acc && paddr == REG_IRQ_STAT) ? pwdata[IRQ_W-1:0] : IRQ_ZERO;

	// A new event in the clearing cycle survives the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_stat_r <= IRQ_ZERO;
		else
			irq_stat_r <= (irq_stat_r & ~irq_w1c) | irq_evt;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_mask_r <= IRQ_ZERO;
		else if (wr_acc && paddr == REG_IRQ_MASK)
			irq_mask_r <= pwdata[IRQ_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_r <= 1'b0;
		else
			irq_r <= |(irq_stat_r & irq_mask_r);
	end
endmodule : dcf_fifo
`default_nettype wire

// [dcf_fifo_chk.sv]
// Port-level assertion checker for the nine-bit FIFO
`default_nettype none
module dcf_fifo_chk (
	input wire logic                       pclk,
	input wire logic                       presetn,
	input wire logic                       rst_n,
	input wire logic                       rd_en_a_n,
	input wire logic                       rd_en_b_n,
	input wire logic                       out_en_n,
	input wire logic [dcf_pkg::DATA_W-1:0] rd_data,
	input wire logic                       rd_data_oe,
	input wire logic                       empty_n,
	input wire logic                       full_n,
	input wire logic                       almost_empty_n,
	input wire logic                       almost_full_n,
	input wire logic                       irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_rst_empty: assert property (!rst_n |=> !empty_n && !almost_empty_n)
		else $error("empty flags not set by fifo reset");
	a_rst_full: assert property (!rst_n |=> full_n && almost_full_n)
		else $error("full flags not cleared by fifo reset");
	a_empty_hold: assert property (($changed(empty_n) ##1 rst_n) |-> $stable(empty_n))
		else $error("empty flag changed twice in a row");
	a_full_hold: assert property (($changed(full_n) ##1 rst_n) |-> $stable(full_n))
		else $error("full flag changed twice in a row");
	a_read_gate: assert property ((rst_n && (rd_en_a_n || rd_en_b_n || !empty_n))
		|=> $stable(rd_data)) else $error("read data moved without a legal read");
	a_oe_follow: assert property (1'b1 |=> rd_data_oe != $past(out_en_n))
		else $error("output enable does not follow its input");
	a_empty_nested: assert property (!empty_n |-> !almost_empty_n)
		else $error("empty without almost empty");
	a_full_nested: assert property (!full_n |-> !almost_full_n)
		else $error("full without almost full");
	a_full_excl: assert property (!full_n |-> empty_n)
		else $error("full and empty together");
	c_full: cover property (!full_n);
	c_refill: cover property ($rose(empty_n));
	c_irq: cover property (irq);
endmodule : dcf_fifo_chk
bind dcf_fifo dcf_fifo_chk u_chk (.pclk(pclk), .presetn(presetn), .rst_n(rst_n),
	.rd_en_a_n(rd_en_a_n), .rd_en_b_n(rd_en_b_n), .out_en_n(out_en_n), .rd_data(rd_data),
	.rd_data_oe(rd_data_oe), .empty_n(empty_n), .full_n(full_n),
	.almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n), .irq(irq));
`default_nettype wire

// [dcf_fifo_peer.sv]
// Producer and consumer logic facing the FIFO data ports
`default_nettype none
module dcf_fifo_peer (
	input  wire logic                       pclk,
	input  wire logic                       rst_n,
	input  wire logic                       full_n,
	input  wire logic                       wr_go,
	input  wire logic                       steer,
	input  wire logic                       rd_go,
	input  wire logic                       blind,
	output logic      [dcf_pkg::DATA_W-1:0] wr_data,
	output logic                            wr_en_a_n,
	output logic                            wr_en_b_or_load_n,
	output logic                            rd_en_a_n,
	output logic                            rd_en_b_n
);
	timeunit 1ns;
	timeprecision 1ns;
	import dcf_pkg::*;
	logic [DATA_W-1:0] cnt_r;
	// Enable A is system control, enable B the expansion steering input
	assign wr_en_a_n = !wr_go;
	assign wr_en_b_or_load_n = steer;
	assign rd_en_a_n = !rd_go;
	assign rd_en_b_n = !rd_go;
	// Blind writes carry the complement of the count, never the word expected next, so a leak shows up
	assign wr_data = blind ? ~cnt_r : cnt_r;
	always_ff @(posedge pclk) begin
		if (!rst_n) begin
			cnt_r <= DATA_ZERO;
		end else if (wr_go && steer && full_n) begin
			cnt_r <= cnt_r + 9'h001;
		end
	end
endmodule : dcf_fifo_peer
`default_nettype wire

// [dcf_gray_sync.sv]
// Gray-coded pointer crossing: encode, two-flop synchroniser, decode
`default_nettype none
module dcf_gray_sync (
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic                    clr,
	input  wire logic [dcf_pkg::PTR_W-1:0] bin_in,
	output logic      [dcf_pkg::PTR_W-1:0] bin_out
);
	import dcf_pkg::*;

	logic [PTR_W-1:0] gray_src_r;
	logic [PTR_W-1:0] meta_r;
	logic [PTR_W-1:0] sync_r;

	// Only one bit of the gray code moves per step, so a late sample is off by one at most
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gray_src_r <= PTR_ZERO;
			meta_r     <= PTR_ZERO;
			sync_r     <= PTR_ZERO;
		end else if (clr) begin
			gray_src_r <= PTR_ZERO;
			meta_r     <= PTR_ZERO;
			sync_r     <= PTR_ZERO;
		end else begin
			gray_src_r <= bin_in ^ (bin_in >> 1);
			meta_r     <= gray_src_r;
			sync_r     <= meta_r;
		end
	end

	genvar i;
	generate
		for (i = 0; i < PTR_W; i++) begin : g_dec
			assign bin_out[i] = ^(sync_r >> i);
		end
	endgenerate
endmodule : dcf_gray_sync
`default_nettype wire

// [dcf_pkg.sv]
// Constants, register map and types shared by the FIFO block
`default_nettype none
package dcf_pkg;
	localparam int DATA_W = 9;
	localparam int ADDR_W = 17;
	localparam int PTR_W  = 18;
	localparam int APB_AW = 8;
	localparam int OFS_W  = 17;
	localparam int IRQ_W  = 4;

	typedef enum logic [1:0] {
		DCF_DEPTH_16K  = 2'b00,
		DCF_DEPTH_64K  = 2'b01,
		DCF_DEPTH_128K = 2'b10
	} dcf_depth_e;

	localparam logic [PTR_W-1:0] WORDS_16K  = 18'h04000;
	localparam logic [PTR_W-1:0] WORDS_64K  = 18'h10000;
	localparam logic [PTR_W-1:0] WORDS_128K = 18'h20000;
	localparam logic [PTR_W-1:0] PTR_ZERO   = 18'h00000;
	localparam logic [PTR_W-1:0] PTR_ONE    = 18'h00001;

	localparam logic [OFS_W-1:0] OFS_RST = 17'h00007;
	localparam dcf_depth_e DEPTH_RST = DCF_DEPTH_128K;

	localparam logic [APB_AW-1:0] REG_CTRL     = 8'h00;
	localparam logic [APB_AW-1:0] REG_AE_OFS   = 8'h04;
	localparam logic [APB_AW-1:0] REG_AF_OFS   = 8'h08;
	localparam logic [APB_AW-1:0] REG_STATUS   = 8'h0c;
	localparam logic [APB_AW-1:0] REG_IRQ_STAT = 8'h10;
	localparam logic [APB_AW-1:0] REG_IRQ_MASK = 8'h14;
	localparam logic [APB_AW-1:0] REG_LEVEL    = 8'h18;

	localparam int CTRL_DEPTH_LSB = 0;
	localparam int CTRL_DEPTH_MSB = 1;
	localparam int CTRL_FLUSH_BIT = 2;

	localparam int IRQ_FULL  = 0;
	localparam int IRQ_EMPTY = 1;
	localparam int IRQ_OVF   = 2;
	localparam int IRQ_UDF   = 3;

	localparam int ST_EMPTY_N  = 0;
	localparam int ST_AEMPTY_N = 1;
	localparam int ST_FULL_N   = 2;
	localparam int ST_AFULL_N  = 3;

	localparam logic [31:0] WORD_ZERO = 32'h00000000;
	localparam logic [DATA_W-1:0] DATA_ZERO = 9'h000;
	localparam logic [IRQ_W-1:0] IRQ_ZERO = 4'h0;

	function automatic logic [PTR_W-1:0] dcf_depth_words(input logic [1:0] code);
		logic [PTR_W-1:0] w;
		w = WORDS_128K;
		unique case (code)
			DCF_DEPTH_16K:  w = WORDS_16K;
			DCF_DEPTH_64K:  w = WORDS_64K;
			DCF_DEPTH_128K: w = WORDS_128K;
			default:        w = WORDS_128K;
		endcase
		return w;
	endfunction : dcf_depth_words
endpackage : dcf_pkg
`default_nettype wire

// [dual_clock_fifo_9bit_flags_bench.sv]
// Self-checking bench for the nine-bit FIFO
`default_nettype none
module dual_clock_fifo_9bit_flags_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import dcf_pkg::*;
	logic pclk = 0, presetn = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic wr_go = 0, rd_go = 0, steer = 1, blind = 0, out_en_n = 1, e;
	logic [APB_AW-1:0] paddr = 8'h00;
	logic [31:0]       pwdata = 32'h0, prdata, q;
	logic [DATA_W-1:0] wr_data, rd_data;
	logic pready, pslverr, wr_en_a_n, wr_en_b_or_load_n, rd_en_a_n, rd_en_b_n;
	logic rd_data_oe, empty_n, full_n, almost_empty_n, almost_full_n, irq;
	int   bad_count = 0;
	int   n_checks = 0;
	always #25 pclk = ~pclk;
	dcf_fifo DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rst_n(rst_n), .wr_data(wr_data), .wr_en_a_n(wr_en_a_n),
		.wr_en_b_or_load_n(wr_en_b_or_load_n), .rd_en_a_n(rd_en_a_n), .rd_en_b_n(rd_en_b_n),
		.out_en_n(out_en_n), .rd_data(rd_data), .rd_data_oe(rd_data_oe), .empty_n(empty_n),
		.full_n(full_n), .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n),
		.irq(irq));
	dcf_fifo_peer u_peer (.pclk(pclk), .rst_n(rst_n), .full_n(full_n), .wr_go(wr_go),
		.steer(steer), .rd_go(rd_go), .blind(blind), .wr_data(wr_data), .wr_en_a_n(wr_en_a_n),
		.wr_en_b_or_load_n(wr_en_b_or_load_n), .rd_en_a_n(rd_en_a_n), .rd_en_b_n(rd_en_b_n));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up
	task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic push(input int n);
		@(posedge pclk);
		wr_go <= 1'b1;
		repeat (n) @(posedge pclk);
		wr_go <= 1'b0;
	endtask : push
	// Reads every cycle and checks each word against the producer's count
	task automatic pull(input int n, input logic [DATA_W-1:0] base);
		@(posedge pclk);
		rd_go <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			if (i == n - 1) rd_go <= 1'b0;
			@(negedge pclk);
			chk("rd_data", rd_data, DATA_W'(base + i));
		end
	endtask : pull
	task automatic flags(input logic [3:0] exp);
		repeat (6) @(posedge pclk);
		chk("flags", {almost_full_n, full_n, almost_empty_n, empty_n}, exp);
	endtask : flags
	initial begin
		repeat (60000) @(posedge pclk);
		bad_count++;
		wrap_up();
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rst_n <= 1'b1;
		out_en_n <= 1'b0;
		flags(4'b1100);
		chk("oe", rd_data_oe, 1'b1);
		apb(1'b0, REG_AE_OFS, 32'h0);
		chk("ae_ofs", q, 32'h7);
		apb(1'b0, REG_AF_OFS, 32'h0);
		chk("af_ofs", q, 32'h7);
		apb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl_rst", q, 32'h2);
		apb(1'b1, REG_CTRL, 32'h1);
		apb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl_64k", q, 32'h1);
		apb(1'b0, 8'h1c, 32'h0);
		chk("unmapped", e, 1'b1);
		apb(1'b1, REG_CTRL, 32'h0);
		apb(1'b1, REG_IRQ_MASK, 32'hf);
		push(7);
		flags(4'b1101);
		apb(1'b0, REG_LEVEL, 32'h0);
		chk("level", q, 32'h7);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status", q, 32'hd);
		push(1);
		flags(4'b1111);
		apb(1'b1, REG_AE_OFS, 32'h8);
		flags(4'b1101);
		steer <= 1'b0;
		push(1);
		steer <= 1'b1;
		pull(8, 9'h000);
		flags(4'b1100);
		pull(1, 9'h007);
		apb(1'b0, REG_IRQ_STAT, 32'h0);
		chk("irq_stat", q, 32'ha);
		chk("irq", irq, 1'b1);
		apb(1'b1, REG_IRQ_STAT, 32'hf);
		apb(1'b1, REG_AE_OFS, 32'h7);
		flags(4'b1100);
		chk("irq", irq, 1'b0);
		push(3);
		rst_n <= 1'b0;
		@(posedge pclk);
		rst_n <= 1'b1;
		flags(4'b1100);
		push(16376);
		flags(4'b1111);
		push(1);
		flags(4'b0111);
		push(7);
		flags(4'b0011);
		blind <= 1'b1;
		push(1);
		blind <= 1'b0;
		apb(1'b0, REG_IRQ_STAT, 32'h0);
		chk("irq_stat", q, 32'h5);
		pull(16384, 9'h000);
		flags(4'b1100);
		push(10);
		fork
			push(10);
			pull(20, 9'h000);
		join
		flags(4'b1100);
		// Flush drops the three stored words; the next two must come out first
		push(3);
		apb(1'b1, REG_CTRL, 32'h4);
		flags(4'b1100);
		apb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl_flush", q, 32'h0);
		push(2);
		flags(4'b1101);
		pull(2, 9'h017);
		wrap_up();
	end
endmodule : dual_clock_fifo_9bit_flags_bench
`default_nettype wire
